// ===== hw/spr_pkg.sv
package spr_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int HOLD_MS = 200;
  localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
  localparam int HOLD_W = 25;
  localparam int REF_FAST_HZ = 1_000_000;
  localparam int REF_SLOW_HZ = 200_000;
  localparam int REF_DIV_FAST = CLK_HZ / REF_FAST_HZ;
  localparam int REF_DIV_SLOW = CLK_HZ / REF_SLOW_HZ;
  localparam int PRE_W = 9;
  localparam int TAP_W = 10;
  localparam int CHAR_W = 8;
  localparam logic [6:0] START_OF_MESSAGE_CODE = 7'h01;
  localparam logic [6:0] END_OF_MESSAGE_CODE = 7'h03;
  localparam logic [7:0] MARKER_CODE = 8'h40;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam logic [7:0] ADDR_PRESET = 8'h0C;
  localparam int CF_PAR = 0;
  localparam int CF_BUSY = 3;
  localparam int CF_GATE = 4;
  localparam int CF_DTR = 5;
  localparam int CF_REF = 7;
  localparam int CF_TAP = 8;
  localparam logic [9:0] TAP_RESET = 10'h034;
  typedef enum logic [2:0] {
    PAR_EVEN = 3'h0,
    PAR_ODD = 3'h1,
    PAR_OFF = 3'h2,
    PAR_EVEN_MARK = 3'h3,
    PAR_ODD_MARK = 3'h4
  } spr_par_t;
  typedef enum logic [1:0] {
    DTR_SEL_IN = 2'h0,
    DTR_SEL_OUT = 2'h1,
    DTR_BUSY_HI = 2'h2,
    DTR_BUSY_LO = 2'h3
  } spr_dtr_t;
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } spr_rx_t;
endpackage

// ===== hw/spr_bit_timer.sv
`timescale 1ns/1ns
module spr_bit_timer
  import spr_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low
  input wire logic run, // counting allowed
  input wire logic ref_fast, // 1 = 1 MHz reference
  input wire logic [TAP_W-1:0] taps, // half-bit in reference ticks
  output logic tick // one pulse per half bit
);
  logic [PRE_W-1:0] pre_q;
  logic [TAP_W-1:0] cnt_q;
  wire [PRE_W-1:0] pre_last = ref_fast ? PRE_W'(REF_DIV_FAST - 1) : PRE_W'(REF_DIV_SLOW - 1);
  wire ref_tick = run && (pre_q == pre_last);
  wire cnt_last = (cnt_q == taps - TAP_W'(1));

  // each set tap adds its binary weight, so the interval is the mask value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else if (!run) begin
      pre_q <= '0;
      cnt_q <= '0;
    end else begin
      pre_q <= ref_tick ? '0 : pre_q + PRE_W'(1);
      if (ref_tick) cnt_q <= cnt_last ? '0 : cnt_q + TAP_W'(1);
    end
  end

  assign tick = ref_tick && cnt_last;
endmodule // spr_bit_timer

// ===== hw/spr_receiver.sv
`timescale 1ns/1ns
// How it works
// - shift in eight bits, seven data plus parity, check, hand over in parallel.
// - in even or odd mode, a message with a parity error gets no reverse-channel acknowledge.
// - end-of-message code raises reverse channel only if message had no even- or odd-mode parity errors.
// - printer busy only stretches an active reverse channel, never starts it.
// - reverse channel lasts at least 200 ms and while busy persists.
// - after reverse channel drops, end-of-message is ignored for 200 ms.
// - bit rate set anywhere from 110 to 9600 baud.
// - bit timing reference is 0.2 MHz below 600 baud, else 1 MHz.
// - half-bit interval is the sum of selected binary-weighted divider taps.
// - parity modes even, odd, off, and even or odd marker-only.
// - presets for direct printer and ring buffer set busy, gate, dtr.
// - with gate disabled, high-count input has no effect.
// - dtr follows select, or is held on permanently.
// - dtr may follow busy in either polarity.
// - a character failing parity is replaced by the marker code.
// - start-of-message code clears the latched parity error unless it fails even- or odd-mode parity itself.
// - start bit needs half a bit of space, then mid-bit sampling.
module spr_receiver
  import spr_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped
  input wire logic rx_line, // serial data, 1 = mark
  input wire logic set_ready, // data set ready
  input wire logic carrier_present, // carrier detected
  input wire logic prn_busy, // printer or buffer busy
  input wire logic prn_select, // printer selected
  input wire logic high_count_gate, // buffer high count
  output logic [CHAR_W-1:0] prn_data, // character to printer
  output logic prn_strobe, // one-cycle data strobe
  output logic rev_channel, // reverse channel to data set
  output logic term_ready // data terminal ready
);
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  spr_rx_t st_q;
  spr_rx_t st_d;
  logic [CHAR_W-1:0] sh_q;
  logic [2:0] bit_q;
  logic phase_q;
  logic done_q;
  logic perr_q;
  logic [CHAR_W-1:0] out_q;
  logic [CHAR_W-1:0] last_q;
  logic strobe_q;
  logic rev_q;
  logic [HOLD_W-1:0] hold_q;
  logic [HOLD_W-1:0] lock_q;
  logic tick;

  // register bus
  wire setup = psel && !penable;
  wire access = psel && penable;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_stat = (paddr == ADDR_STATUS);
  wire hit_rxd = (paddr == ADDR_RXDATA);
  wire hit_pre = (paddr == ADDR_PRESET);
  wire mapped = hit_ctrl || hit_stat || hit_rxd || hit_pre;
  wire wr_ctrl = access && pwrite && hit_ctrl;
  wire wr_pre = access && pwrite && hit_pre;
  wire rx_busy = (st_q != RX_IDLE);
  wire [31:0] stat_word = {28'h0000000, rx_busy, (lock_q != '0), perr_q, rev_q};
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_stat ? stat_word :
                       hit_rxd ? {24'h000000, last_q} : 32'h00000000;

  // presets: 0 direct printer, 1 ring buffer; parity field kept
  wire ring = pwdata[0];
  wire [31:0] preset_word = {ctrl_q[31:CF_DTR+2],
                             ring ? DTR_SEL_OUT : DTR_SEL_IN,
                             ring, !ring, ctrl_q[2:0]};
  // constant so the async reset branch loads nothing but a constant
  localparam logic [31:0] CTRL_RESET = {14'h0000, TAP_RESET, 1'b1, 2'(DTR_SEL_IN), 1'b0, 1'b1, 3'(PAR_EVEN)};

  // config fields
  wire [2:0] par_mode = ctrl_q[CF_PAR +: 3];
  wire busy_en = ctrl_q[CF_BUSY];
  wire gate_en = ctrl_q[CF_GATE];
  wire [1:0] dtr_mode = ctrl_q[CF_DTR +: 2];
  wire ref_fast = ctrl_q[CF_REF];
  wire [TAP_W-1:0] taps = ctrl_q[CF_TAP +: TAP_W];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= {14'h0000, pwdata[17:0]};
    end else if (wr_pre) begin
      ctrl_q <= preset_word;
    end
  end

  // read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata_q <= 32'h00000000;
    else if (setup) prdata_q <= rd_mux;
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;

  // bit timing, 110 to 9600 baud through reference and taps
  spr_bit_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .run(rx_busy && st_q != RX_STOP),
    .ref_fast(ref_fast),
    .taps(taps),
    .tick(tick)
  );

  // receive sequencer
  wire space = !rx_line;
  wire line_ok = set_ready && carrier_present;
  wire sample = (st_q == RX_DATA) && tick && phase_q;
  wire last_bit = sample && (bit_q == 3'h7);

  always_comb begin
    st_d = st_q;
    case (st_q)
      RX_IDLE: begin
        if (space && line_ok) st_d = RX_START;
      end
      RX_START: begin
        if (!space) st_d = RX_IDLE;
        else if (tick) st_d = RX_DATA;
      end
      RX_DATA: begin
        if (last_bit) st_d = RX_STOP;
      end
      RX_STOP: begin
        if (!space) st_d = RX_IDLE;
      end
      default: st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) st_q <= RX_IDLE;
    else st_q <= st_d;
  end

  // mid-bit is every second half-bit tick after the start check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_q <= '0;
      bit_q <= '0;
      phase_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= last_bit;
      if (st_q != RX_DATA) begin
        bit_q <= '0;
        phase_q <= 1'b0;
      end else if (tick) begin
        phase_q <= !phase_q;
      end
      if (sample) begin
        sh_q <= {rx_line, sh_q[CHAR_W-1:1]};
        bit_q <= bit_q + 3'h1;
      end
    end
  end

  // parity judgement on the assembled character
  wire odd_ones = ^sh_q;
  wire want_odd = (par_mode == PAR_ODD) || (par_mode == PAR_ODD_MARK);
  wire checking = (par_mode != PAR_OFF);
  wire bad_now = done_q && checking && (odd_ones != want_odd);
  wire counts = (par_mode == PAR_EVEN) || (par_mode == PAR_ODD);
  wire is_start_code = done_q && (sh_q[6:0] == START_OF_MESSAGE_CODE);
  wire is_end_code = done_q && (sh_q[6:0] == END_OF_MESSAGE_CODE);

  // marker-only modes substitute but never withhold the acknowledge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) perr_q <= 1'b0;
    else if (bad_now && counts) perr_q <= 1'b1;
    else if (is_start_code) perr_q <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= '0;
      last_q <= '0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= done_q;
      if (done_q) begin
        out_q <= bad_now ? MARKER_CODE : sh_q;
        last_q <= sh_q;
      end
    end
  end

  assign prn_data = out_q;
  assign prn_strobe = strobe_q;

  // reverse channel
  wire msg_clean = !perr_q && !(bad_now && counts);
  wire lock_free = (lock_q == '0);
  wire activate = is_end_code && msg_clean && !rev_q && lock_free;
  wire extend = (busy_en && prn_busy) || (gate_en && high_count_gate);
  wire hold_done = (hold_q == '0);
  wire release_now = rev_q && hold_done && !extend;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rev_q <= 1'b0;
      hold_q <= '0;
    end else if (activate) begin
      rev_q <= 1'b1;
      hold_q <= HOLD_W'(HOLD_CYCLES - 1);
    end else if (rev_q) begin
      if (!hold_done) hold_q <= hold_q - HOLD_W'(1);
      else if (!extend) rev_q <= 1'b0;
    end
  end

  // lockout timed here so a stray end code cannot retrigger early
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) lock_q <= '0;
    else if (release_now) lock_q <= HOLD_W'(HOLD_CYCLES - 1);
    else if (!lock_free) lock_q <= lock_q - HOLD_W'(1);
  end

  assign rev_channel = rev_q;

  // terminal ready
  wire dtr_d = (dtr_mode == DTR_SEL_OUT) ? 1'b1 :
               (dtr_mode == DTR_BUSY_HI) ? prn_busy :
               (dtr_mode == DTR_BUSY_LO) ? !prn_busy : prn_select;
  logic dtr_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dtr_q <= 1'b0;
    else dtr_q <= dtr_d;
  end
  assign term_ready = dtr_q;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence clean_end_s;
    is_end_code && msg_clean && !rev_q && lock_free;
  endsequence

  end_ack_a: assert property (clean_end_s |=> rev_q ##1 rev_q)
    else $error("clean end code did not raise reverse channel");
  perr_withhold_a: assert property (is_end_code && !msg_clean && !rev_q |=> !rev_q)
    else $error("reverse channel raised despite parity error");
  busy_nostart_a: assert property (!rev_q && !activate && prn_busy |=> !rev_q)
    else $error("busy started reverse channel");
  rev_min_a: assert property (rev_q && !hold_done |=> rev_q)
    else $error("reverse channel dropped before minimum time");
  rev_extend_a: assert property (rev_q && extend |=> rev_q)
    else $error("reverse channel dropped while busy");
  lockout_a: assert property ($fell(rev_q) |-> !rev_q [*8] ##1 (lock_q != '0))
    else $error("reverse channel reactivated in lockout");
  marker_sub_a: assert property (bad_now |=> prn_strobe && prn_data == MARKER_CODE)
    else $error("bad character not replaced by marker");
  good_pass_a: assert property (done_q && !bad_now ##1 1'b1 |-> prn_strobe && prn_data == $past(sh_q))
    else $error("good character not passed intact");
  start_clear_a: assert property (is_start_code && !bad_now |=> !perr_q)
    else $error("start code did not clear parity error");
  start_glitch_a: assert property (st_q == RX_START && !space |=> st_q == RX_IDLE)
    else $error("short space accepted as start bit");
  timer_idle_a: assert property (st_q == RX_IDLE |-> !tick)
    else $error("bit timer ran while idle");
  dtr_hold_a: assert property (dtr_mode == DTR_SEL_OUT ##1 dtr_mode == DTR_SEL_OUT |-> term_ready)
    else $error("terminal ready not held in select-out mode");
endmodule // spr_receiver

// ===== verification/spr_modem_model.sv
`timescale 1ns/1ns
module spr_modem_model (
  input wire logic pclk, // bus clock
  output logic rx_line, // serial data, 1 = mark
  output logic set_ready, // data set ready
  output logic carrier_present // carrier detected
);
  // line rests at mark between frames, as a real data set does
  initial begin
    rx_line = 1'b1;
    set_ready = 1'b1;
    carrier_present = 1'b1;
  end

  // start, eight bits lsb first, then two bit times of mark
  task automatic send_char(input logic [7:0] c, input int bit_cyc);
    logic [9:0] frame;
    frame = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk);
      rx_line <= frame[i];
      repeat (bit_cyc - 1) @(posedge pclk);
    end
    repeat (bit_cyc) @(posedge pclk);
  endtask
endmodule // spr_modem_model

// ===== verification/spr_receiver_tb_top.sv
`timescale 1ns/1ns
module spr_receiver_tb_top;
  import spr_pkg::*;
  localparam int HOLD = 3000;
  // taps 1 at the 1 MHz reference: half bit 100 cycles keeps the run short
  localparam int BITC = 200;
  localparam logic [31:0] CTRL_RUN = 32'h00000188;
  localparam logic [3:0] DTR_EXP = 4'h6;
  localparam logic [7:0] PAR_EXP [5] = '{8'h41, 8'h40, 8'h41, 8'h41, 8'h40};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_line, set_ready, carrier_present;
  logic prn_busy, prn_select, high_count_gate, prn_strobe, rev_channel, term_ready, err;
  logic [7:0] paddr, prn_data;
  logic [31:0] pwdata, prdata, rd;
  int n_errors, checked;
  time t_stb;

  spr_receiver #(.HOLD_CYCLES(HOLD)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .set_ready(set_ready), .carrier_present(carrier_present), .prn_busy(prn_busy),
    .prn_select(prn_select), .high_count_gate(high_count_gate), .prn_data(prn_data),
    .prn_strobe(prn_strobe), .rev_channel(rev_channel), .term_ready(term_ready));
  spr_modem_model i_modem (.pclk(pclk), .rx_line(rx_line), .set_ready(set_ready),
    .carrier_present(carrier_present));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic finish_test();
    if (n_errors == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] ep(input logic [6:0] d);
    return {^d, d};
  endfunction

  // parity bit is not compared: only the seven data bits reach the printer meaningfully
  task automatic rx_char(input logic [7:0] c, input logic [7:0] exp_d, input logic exp_r);
    logic seen;
    seen = 1'b0;
    fork
      i_modem.send_char(c, BITC);
      repeat (2000) begin
        @(posedge pclk);
        if (!seen && prn_strobe === 1'b1) begin
          seen = 1'b1;
          t_stb = $time;
          chk("prn_data", prn_data & 8'h7F, exp_d);
          chk("rev_channel at strobe", rev_channel, exp_r);
        end
      end
    join
    chk("prn_strobe", seen, 1'b1);
  endtask

  // lands between edges, n cycles after the strobe was seen
  task automatic wait_rel(input int n);
    #(t_stb + n * 10 + 1 - $time);
  endtask

  initial begin
    #800_000;
    n_errors++;
    finish_test();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
    {prn_busy, prn_select, high_count_gate, n_errors, checked, t_stb} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("rev_channel", rev_channel, 1'b0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h00003488);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, ADDR_PRESET, 32'h1);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("ring preset", rd, 32'h000034B0);
    apb(1'b1, ADDR_PRESET, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk("direct preset", rd, 32'h00003488);
    prn_busy <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ADDR_CTRL, 32'h00003488 | (32'(m) << 5));
      repeat (3) @(posedge pclk);
      chk("term_ready", term_ready, DTR_EXP[m]);
    end
    prn_busy <= 1'b0;
    prn_select <= 1'b1;
    apb(1'b1, ADDR_CTRL, 32'h00003488);
    repeat (3) @(posedge pclk);
    chk("term_ready selected", term_ready, 1'b1);
    prn_select <= 1'b0;
    for (int p = 0; p < 5; p++) begin
      apb(1'b1, ADDR_CTRL, CTRL_RUN | 32'(p));
      rx_char(ep(7'h41), PAR_EXP[p], 1'b0);
    end
    apb(1'b1, ADDR_CTRL, CTRL_RUN);
    rx_char(ep(START_OF_MESSAGE_CODE), 8'h01, 1'b0);
    rx_char(ep(7'h41), 8'h41, 1'b0);
    prn_busy <= 1'b1;
    rx_char(ep(7'h0E), 8'h0E, 1'b0);
    rx_char(ep(END_OF_MESSAGE_CODE), 8'h03, 1'b1);
    wait_rel(HOLD + 3);
    chk("rev held by busy", rev_channel, 1'b1);
    @(posedge pclk);
    prn_busy <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("rev after busy", rev_channel, 1'b0);
    rx_char(ep(END_OF_MESSAGE_CODE), 8'h03, 1'b0);
    repeat (HOLD) @(posedge pclk);
    high_count_gate <= 1'b1;
    rx_char(ep(END_OF_MESSAGE_CODE), 8'h03, 1'b1);
    wait_rel(HOLD - 3);
    chk("rev minimum", rev_channel, 1'b1);
    wait_rel(HOLD + 3);
    chk("rev end", rev_channel, 1'b0);
    @(posedge pclk);
    prn_busy <= 1'b1;
    high_count_gate <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("busy alone", rev_channel, 1'b0);
    prn_busy <= 1'b0;
    rx_char(8'hC1, 8'h40, 1'b0);
    rx_char(ep(END_OF_MESSAGE_CODE), 8'h03, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("error latched", rd & 32'h2, 32'h2);
    rx_char(ep(START_OF_MESSAGE_CODE), 8'h01, 1'b0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk("error cleared", rd & 32'h2, 32'h0);
    rx_char(ep(END_OF_MESSAGE_CODE), 8'h03, 1'b1);
    finish_test();
  end
endmodule // spr_receiver_tb_top
